// file: logic/wrs_pkg.sv
// shared constants and types of the reset supervisor and watchdog
package wrs_pkg;
  // special-function register addresses
  localparam logic [7:0] WRS_ADDR_POWER_CONTROL = 8'h87;
  localparam logic [7:0] WRS_ADDR_WATCHDOG_RELOAD = 8'ha6;
  localparam logic [7:0] WRS_ADDR_WATCHDOG_KEY = 8'hae;
  // field positions and values
  localparam int WRS_LVR_DISABLE_BIT = 5;
  localparam logic [7:0] WRS_KEY_DISABLE = 8'h55;
  localparam logic [7:0] WRS_KEY_RESET = 8'h00;
  localparam logic [7:0] WRS_POWER_CONTROL_RESET = 8'h00;
  localparam int WRS_RELOAD_BITS = 7;
  // watchdog geometry
  localparam int WRS_WDT_WIDTH = 22;
  localparam int WRS_WDT_PULSE_MC = 32768;
  // timing
  localparam int WRS_CLK_HZ = 25000000;
  localparam int WRS_MC_DIV = 12;
  localparam int WRS_LVR_HOLD_MS = 10;
  localparam int WRS_LVR_HOLD_CYCLES = WRS_CLK_HZ / 1000 * WRS_LVR_HOLD_MS;
  localparam int WRS_SE0_MIN_SAMPLES = 4;
  localparam int WRS_USB_SAMPLE_DIV = 16;

  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } wrs_sfr_req_t;

  typedef struct packed {
    logic pin;
    logic low_voltage;
    logic watchdog;
    logic usb;
  } wrs_cause_t;
endpackage

// file: logic/wrs_stretch.sv
// holds a request active, then for a fixed number of ticks after it drops
`timescale 1ns/1ps
module wrs_stretch import wrs_pkg::*; #(
  parameter int CYCLES = 16
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  // control
  input wire logic req_in,
  input wire logic tick_in,
  // status
  output logic active_out
);
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LOAD = CW'(CYCLES);
  localparam logic [CW-1:0] ONE = CW'(1);

  logic [CW-1:0] cnt_q;
  logic active_q;

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt_q <= '0;
    end else if (req_in) begin
      cnt_q <= LOAD;
    end else if (tick_in && cnt_q != '0) begin
      cnt_q <= cnt_q - ONE;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      active_q <= 1'b0;
    end else begin
      active_q <= req_in || (cnt_q != '0 && !(tick_in && cnt_q == ONE));
    end
  end

  assign active_out = active_q;
endmodule

// file: logic/wrs_se0_detect.sv
// counts consecutive single-ended-zero samples on the upstream port
`timescale 1ns/1ps
module wrs_se0_detect import wrs_pkg::*; #(
  parameter int MIN_SAMPLES = WRS_SE0_MIN_SAMPLES
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  // line samples
  input wire logic sample_in,
  input wire logic se0_in,
  // result
  output logic detect_out
);
  localparam int CW = $clog2(MIN_SAMPLES + 1);
  localparam logic [CW-1:0] LIMIT = CW'(MIN_SAMPLES);
  localparam logic [CW-1:0] ONE = CW'(1);

  logic [CW-1:0] run_q;

  // counter saturates, so a long bus reset keeps detect high
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      run_q <= '0;
    end else if (sample_in) begin
      if (!se0_in) begin
        run_q <= '0;
      end else if (run_q != LIMIT) begin
        run_q <= run_q + ONE;
      end
    end
  end

  assign detect_out = (run_q == LIMIT);
endmodule

// file: logic/wrs_supervisor.sv
// reset supervisor: merges reset sources and runs the 22-bit watchdog
// Functional notes
// RULE_01: any of four sources asserts internal reset
// RULE_02: internal reset forwarded active low to logic module
// RULE_03: host holds reset pin low 1ms minimum
// RULE_04: low-voltage reset held 10ms after recovery
// RULE_05: low-voltage reset default on, software may disable
// RULE_06: low-voltage reset works in idle and power-down
// RULE_07: four to eight SE0 samples set bus-reset flag
// RULE_08: enable bit six routes bus reset to reset
// RULE_09: 22-bit counter increments every machine cycle
// RULE_10: overflow after 4194304 cycles causes internal reset
// RULE_11: watchdog enabled at power-up and every reset
// RULE_12: watchdog and reset logic keep running in idle
// RULE_13: reload value fills counter upper seven bits
// RULE_14: reload write of zero clears whole counter
// RULE_15: only key 55h disables the watchdog
// RULE_16: overflow reset pulse lasts 2^15 machine cycles
// RULE_17: software should wake from idle to service
// RULE_18: power control bit five disables low-voltage reset
// RULE_19: internal reset clears counter and key
`timescale 1ns/1ps
module wrs_supervisor import wrs_pkg::*; #(
  parameter int LVR_HOLD_CYCLES = WRS_LVR_HOLD_CYCLES,
  parameter int WDT_PULSE_MC = WRS_WDT_PULSE_MC,
  parameter int MC_DIV = WRS_MC_DIV,
  parameter int USB_SAMPLE_DIV = WRS_USB_SAMPLE_DIV,
  parameter int SE0_MIN_SAMPLES = WRS_SE0_MIN_SAMPLES
) (
  // clock and power-on reset
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  // reset sources from pins and analog
  input wire logic reset_pin_b_in,
  input wire logic low_voltage_in,
  input wire logic usb_se0_in,
  // usb register interface
  input wire logic usb_bus_reset_enable_in,
  input wire logic usb_bus_reset_flag_clr_in,
  output logic usb_bus_reset_flag_out,
  // cpu special-function register bus
  input wire wrs_sfr_req_t sfr_req_in,
  output logic [7:0] sfr_rdata_out,
  output logic sfr_hit_out,
  // status
  output logic [WRS_WDT_WIDTH-1:0] watchdog_counter_out,
  output logic machine_cycle_out,
  output wrs_cause_t reset_cause_out,
  // merged reset outputs
  output logic cpu_reset_b_out,
  output logic logic_module_reset_b_out
);
  localparam int MCW = $clog2(MC_DIV);
  localparam int USW = $clog2(USB_SAMPLE_DIV);
  localparam logic [MCW-1:0] MC_LAST = MCW'(MC_DIV - 1);
  localparam logic [MCW-1:0] MC_ONE = MCW'(1);
  localparam logic [USW-1:0] US_LAST = USW'(USB_SAMPLE_DIV - 1);
  localparam logic [USW-1:0] US_ONE = USW'(1);
  localparam logic [WRS_WDT_WIDTH-1:0] WDT_MAX = {WRS_WDT_WIDTH{1'b1}};
  localparam logic [WRS_WDT_WIDTH-1:0] WDT_ONE = WRS_WDT_WIDTH'(1);
  localparam int LOW_BITS = WRS_WDT_WIDTH - WRS_RELOAD_BITS;

  // two-stage synchronisers for pin-side levels
  logic [2:0] async_raw;
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  assign async_raw = {reset_pin_b_in, low_voltage_in, usb_se0_in};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          // all stages reset low: idle for the level inputs, asserted for the pin,
          // so the internal reset cannot blip off before the pin is really seen
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
        end else begin
          sync1_q[gi] <= async_raw[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate

  logic pin_reset_req;
  logic low_voltage_s;
  logic se0_s;
  assign pin_reset_req = !sync2_q[2];
  assign low_voltage_s = sync2_q[1];
  assign se0_s = sync2_q[0];

  // machine-cycle enable from the oscillator clock
  // a one-cycle enable rather than a derived clock, so nothing leaves this domain
  logic [MCW-1:0] mc_cnt_q;
  logic mc_tick;
  assign mc_tick = (mc_cnt_q == MC_LAST);

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      mc_cnt_q <= '0;
    end else if (mc_tick) begin
      mc_cnt_q <= '0;
    end else begin
      mc_cnt_q <= mc_cnt_q + MC_ONE;
    end
  end

  // usb line sample-time enable
  // spacing is a parameter chosen to suit the line rate
  logic [USW-1:0] us_cnt_q;
  logic us_tick;
  assign us_tick = (us_cnt_q == US_LAST);

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      us_cnt_q <= '0;
    end else if (us_tick) begin
      us_cnt_q <= '0;
    end else begin
      us_cnt_q <= us_cnt_q + US_ONE;
    end
  end

  // merged internal reset, registered so every source lines up
  // one cycle of latency on every source, traded for a glitch-free output
  logic int_rst_q;
  logic lvr_active;
  logic wdt_active;
  logic usb_reset_req;
  logic any_req;

  // register file
  logic [7:0] key_q;
  logic lvr_disable_q;
  logic [WRS_WDT_WIDTH-1:0] wdt_q;
  logic wr_reload;
  logic wr_key;
  logic wr_power;
  logic wdt_enabled;
  logic wdt_overflow;

  assign wr_reload = sfr_req_in.wr && sfr_req_in.addr == WRS_ADDR_WATCHDOG_RELOAD;
  assign wr_key = sfr_req_in.wr && sfr_req_in.addr == WRS_ADDR_WATCHDOG_KEY;
  assign wr_power = sfr_req_in.wr && sfr_req_in.addr == WRS_ADDR_POWER_CONTROL;

  // writes are dropped while the internal reset stands, as the reset branch wins
  // any internal reset drops a disable key, so the watchdog restarts armed
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      key_q <= WRS_KEY_RESET;
    end else if (int_rst_q) begin
      key_q <= WRS_KEY_RESET; // see RULE_19 see RULE_11
    end else if (wr_key) begin
      key_q <= sfr_req_in.wdata;
    end
  end

  // an internal reset re-enables low-voltage reset, matching its power-up state
  // only the lvr disable bit of the power control register lives here
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      lvr_disable_q <= WRS_POWER_CONTROL_RESET[WRS_LVR_DISABLE_BIT]; // see RULE_05
    end else if (int_rst_q) begin
      lvr_disable_q <= WRS_POWER_CONTROL_RESET[WRS_LVR_DISABLE_BIT]; // see RULE_18
    end else if (wr_power) begin
      lvr_disable_q <= sfr_req_in.wdata[WRS_LVR_DISABLE_BIT]; // see RULE_18
    end
  end

  // idle mode stops only the cpu, so nothing here looks at it
  assign wdt_enabled = (key_q != WRS_KEY_DISABLE); // see RULE_15 see RULE_12
  assign wdt_overflow = wdt_enabled && mc_tick && wdt_q == WDT_MAX; // see RULE_10

  // reload beats counting in the counter, but a service write on the overflow tick still lets the overflow reset through
  // at overflow the counter wraps to zero and the internal reset holds it there
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wdt_q <= '0;
    end else if (int_rst_q) begin
      wdt_q <= '0; // see RULE_19
    end else if (wr_reload) begin
      // bit 7 is reserved and ignored; zero clears low bits too
      wdt_q <= {sfr_req_in.wdata[WRS_RELOAD_BITS-1:0], {LOW_BITS{1'b0}}}; // see RULE_13 RULE_14
    end else if (wdt_enabled && mc_tick) begin
      wdt_q <= wdt_q + WDT_ONE; // see RULE_09
    end
  end

  // watchdog reset pulse counted in machine cycles
  // its length does not follow the reload value, only the machine-cycle rate
  wrs_stretch #(
    .CYCLES(WDT_PULSE_MC)
  ) u_wdt_pulse (
    .clk_sys_in(clk_sys_in),
    .rst_b_in(rst_b_in),
    .req_in(wdt_overflow),
    .tick_in(mc_tick),
    .active_out(wdt_active)
  ); // see RULE_16

  // low-voltage hold counted in oscillator cycles; no clock gating here,
  // so it keeps working whatever power mode the cpu is in
  wrs_stretch #(
    .CYCLES(LVR_HOLD_CYCLES)
  ) u_lvr_hold (
    .clk_sys_in(clk_sys_in),
    .rst_b_in(rst_b_in),
    .req_in(low_voltage_s && !lvr_disable_q),
    .tick_in(1'b1),
    .active_out(lvr_active)
  ); // see RULE_04 see RULE_06

  // bus reset detection
  logic se0_detect;
  logic flag_q;

  wrs_se0_detect #(
    .MIN_SAMPLES(SE0_MIN_SAMPLES)
  ) u_se0 (
    .clk_sys_in(clk_sys_in),
    .rst_b_in(rst_b_in),
    .sample_in(us_tick),
    .se0_in(se0_s),
    .detect_out(se0_detect)
  ); // see RULE_07

  // set wins over clear; not cleared by internal reset so the cause survives
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      flag_q <= 1'b0;
    end else if (se0_detect) begin
      flag_q <= 1'b1; // see RULE_07
    end else if (usb_bus_reset_flag_clr_in) begin
      flag_q <= 1'b0;
    end
  end

  // the usb request lasts only while the line stays in single-ended zero
  assign usb_reset_req = se0_detect && usb_bus_reset_enable_in; // see RULE_08
  assign any_req = pin_reset_req || lvr_active || wdt_active || usb_reset_req; // see RULE_01

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      // starts asserted so nothing downstream runs before the first edge
      int_rst_q <= 1'b1;
    end else begin
      int_rst_q <= any_req; // see RULE_01
    end
  end

  // last cause seen, sticky until the next request
  // overlapping sources all show; the last requesting cycle decides
  wrs_cause_t cause_q;
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cause_q <= '0;
    end else if (any_req) begin
      cause_q <= '{pin: pin_reset_req, low_voltage: lvr_active,
                   watchdog: wdt_active, usb: usb_reset_req};
    end
  end

  // register read path; reload register is write-only and reads zero
  // reads have no side effects, so a polling cpu cannot disturb the watchdog
  logic [7:0] rdata_q;
  logic hit_q;
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdata_q <= 8'h00;
      hit_q <= 1'b0;
    end else begin
      hit_q <= 1'b0;
      rdata_q <= 8'h00;
      if (sfr_req_in.rd) begin
        case (sfr_req_in.addr)
          WRS_ADDR_WATCHDOG_KEY: begin
            rdata_q <= key_q;
            hit_q <= 1'b1;
          end
          WRS_ADDR_POWER_CONTROL: begin
            rdata_q <= 8'(lvr_disable_q) << WRS_LVR_DISABLE_BIT;
            hit_q <= 1'b1;
          end
          WRS_ADDR_WATCHDOG_RELOAD: begin
            hit_q <= 1'b1;
          end
          default: begin
            hit_q <= 1'b0;
          end
        endcase
      end
    end
  end

  assign sfr_rdata_out = rdata_q;
  assign sfr_hit_out = hit_q;
  assign usb_bus_reset_flag_out = flag_q;
  assign watchdog_counter_out = wdt_q;
  assign machine_cycle_out = mc_tick;
  assign reset_cause_out = cause_q;
  // both reset outputs come from one flop, so they can never disagree
  assign cpu_reset_b_out = !int_rst_q;
  assign logic_module_reset_b_out = !int_rst_q; // see RULE_02
endmodule

// file: verification/wrs_supervisor_properties.sv
// port-level assertions for the reset supervisor and watchdog
`timescale 1ns/1ps
module wrs_supervisor_properties import wrs_pkg::*; (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  // watched ports
  input wire logic reset_pin_b_in,
  input wire logic low_voltage_in,
  input wire logic usb_se0_in,
  input wire logic usb_bus_reset_enable_in,
  input wire logic usb_bus_reset_flag_out,
  input wire wrs_sfr_req_t sfr_req_in,
  input wire logic [7:0] sfr_rdata_out,
  input wire logic sfr_hit_out,
  input wire logic [WRS_WDT_WIDTH-1:0] watchdog_counter_out,
  input wire logic machine_cycle_out,
  input wire logic cpu_reset_b_out,
  input wire logic logic_module_reset_b_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);
  logic rel;
  // writes are dropped while the internal reset is active
  assign rel = sfr_req_in.wr && sfr_req_in.addr == WRS_ADDR_WATCHDOG_RELOAD && cpu_reset_b_out;
  AST_FWD: assert property (logic_module_reset_b_out == cpu_reset_b_out)
    else $error("logic module reset differs from cpu reset");
  AST_PIN: assert property (!reset_pin_b_in [*4] |-> !cpu_reset_b_out)
    else $error("pin reset not merged");
  AST_LVR_HOLD: assert property ($fell(low_voltage_in) && !cpu_reset_b_out
    |=> !cpu_reset_b_out [*8]) else $error("low voltage reset released early");
  AST_USB_FLAG: assert property ($rose(usb_bus_reset_flag_out)
    |-> $past(usb_se0_in, 4) && $past(usb_se0_in, 7)) else $error("flag without se0 run");
  AST_USB_EN: assert property ($rose(usb_bus_reset_flag_out) && usb_bus_reset_enable_in
    |-> ##[0:2] !cpu_reset_b_out) else $error("enabled bus reset did not reset");
  AST_MC: assert property (machine_cycle_out |=> !machine_cycle_out [*8])
    else $error("machine cycle pulses too close");
  AST_INC: assert property (cpu_reset_b_out && $past(cpu_reset_b_out) && !$past(rel)
    && $changed(watchdog_counter_out) |-> watchdog_counter_out == $past(watchdog_counter_out) + 22'h1)
    else $error("watchdog counter moved by other than one");
  AST_LOAD: assert property (rel && sfr_req_in.wdata[6:0] != 7'h00
    |=> watchdog_counter_out == {$past(sfr_req_in.wdata[6:0]), 15'h0000})
    else $error("reload not placed in upper bits");
  AST_ZERO: assert property (rel && sfr_req_in.wdata[6:0] == 7'h00
    |=> watchdog_counter_out == 22'h000000) else $error("zero reload did not clear");
  AST_RD_WO: assert property (sfr_req_in.rd && sfr_req_in.addr == WRS_ADDR_WATCHDOG_RELOAD
    |=> sfr_hit_out && sfr_rdata_out == 8'h00) else $error("reload register read not zero");
  AST_REL_CLR: assert property ($rose(cpu_reset_b_out) |-> watchdog_counter_out <= 22'h000001)
    else $error("counter not cleared by reset");
endmodule

bind wrs_supervisor wrs_supervisor_properties i_props (.clk_sys_in, .rst_b_in, .reset_pin_b_in,
  .low_voltage_in, .usb_se0_in, .usb_bus_reset_enable_in, .usb_bus_reset_flag_out, .sfr_req_in,
  .sfr_rdata_out, .sfr_hit_out, .watchdog_counter_out, .machine_cycle_out, .cpu_reset_b_out,
  .logic_module_reset_b_out);

// file: verification/wrs_cpu_model.sv
// cpu core side of the special-function register bus
`timescale 1ns/1ps
module wrs_cpu_model import wrs_pkg::*; (
  // clock
  input wire logic clk_sys_in,
  // bus
  output wrs_sfr_req_t sfr_req_out,
  input wire logic [7:0] sfr_rdata_in,
  input wire logic sfr_hit_in
);
  initial sfr_req_out = '0;
  // one-cycle strobe, launched and dropped on falling edges
  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys_in);
    sfr_req_out = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(negedge clk_sys_in);
    sfr_req_out = '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
  endtask
  // answer is registered at the taking edge and read at the next falling edge
  task automatic sfr_rd(input logic [7:0] a, output logic [7:0] d, output logic h);
    @(negedge clk_sys_in);
    sfr_req_out = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(negedge clk_sys_in);
    d = sfr_rdata_in;
    h = sfr_hit_in;
    sfr_req_out = '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: 8'hff};
  endtask
endmodule

// file: verification/tb_watchdog_reset_supervisor.sv
// self-checking bench of the reset supervisor and watchdog
`timescale 1ns/1ps
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin errors++; \
  $display("[ERR] %s exp %h got %h", n, e, s); end end
module tb_watchdog_reset_supervisor import wrs_pkg::*;;
  logic clk_sys_in = 1'b0, rst_b_in = 1'b0, pin_b = 1'b0, lv = 1'b0, se0 = 1'b0, en = 1'b0;
  logic clr = 1'b0, flag, hit, mc, rst_b, lm_b;
  logic [7:0] rd_d;
  logic [21:0] cnt, c0;
  wrs_sfr_req_t req;
  wrs_cause_t cause;
  int errors = 0, check_count = 0, cyc = 0;
  int mcs = 0, m0 = 0;
  initial forever #20 clk_sys_in = ~clk_sys_in;
  // pulses taken at the edge that consumes them, before the divider moves on
  always @(posedge clk_sys_in) begin
    if (mc === 1'b1) mcs++;
  end
  wrs_supervisor #(.LVR_HOLD_CYCLES(20), .WDT_PULSE_MC(8), .USB_SAMPLE_DIV(2)) i_dut (
    .clk_sys_in, .rst_b_in, .reset_pin_b_in(pin_b), .low_voltage_in(lv), .usb_se0_in(se0),
    .usb_bus_reset_enable_in(en), .usb_bus_reset_flag_clr_in(clr), .usb_bus_reset_flag_out(flag),
    .sfr_req_in(req), .sfr_rdata_out(rd_d), .sfr_hit_out(hit), .watchdog_counter_out(cnt),
    .machine_cycle_out(mc), .reset_cause_out(cause), .cpu_reset_b_out(rst_b),
    .logic_module_reset_b_out(lm_b));
  wrs_cpu_model i_cpu (.clk_sys_in, .sfr_req_out(req), .sfr_rdata_in(rd_d), .sfr_hit_in(hit));
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic eh);
    logic [7:0] d;
    logic h;
    i_cpu.sfr_rd(a, d, h);
    `CHK("rdata", e, d)
    `CHK("hit", eh, h)
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 40000) begin
      errors++;
      final_report;
    end
  end
  initial begin
    wt(6);
    rst_b_in = 1'b1;
    wt(25000);
    `CHK("pin reset", 1'b0, rst_b)
    pin_b = 1'b1;
    wt(5);
    `CHK("reset out", 1'b1, rst_b)
    `CHK("module reset", rst_b, lm_b)
    `CHK("pin cause", 4'b1000, cause)
    i_cpu.sfr_wr(WRS_ADDR_WATCHDOG_RELOAD, 8'h1e);
    `CHK("reload", 22'h0f0000, cnt)
    i_cpu.sfr_wr(WRS_ADDR_WATCHDOG_RELOAD, 8'h00);
    `CHK("clear", 22'h000000, cnt)
    i_cpu.sfr_wr(WRS_ADDR_WATCHDOG_KEY, WRS_KEY_DISABLE);
    rd(WRS_ADDR_WATCHDOG_KEY, 8'h55, 1'b1);
    c0 = cnt;
    wt(30);
    `CHK("frozen", c0, cnt)
    i_cpu.sfr_wr(WRS_ADDR_WATCHDOG_KEY, 8'h54);
    c0 = cnt;
    m0 = mcs;
    wt(120);
    `CHK("mc pulses", 10, mcs - m0)
    `CHK("running", c0 + 22'd10, cnt)
    repeat (3) begin
      wt(60);
      i_cpu.sfr_wr(WRS_ADDR_WATCHDOG_RELOAD, 8'h7e);
      `CHK("service", 22'h3f0000, cnt)
    end
    rd(WRS_ADDR_WATCHDOG_RELOAD, 8'h00, 1'b1);
    rd(8'h55, 8'h00, 1'b0);
    i_cpu.sfr_wr(WRS_ADDR_POWER_CONTROL, 8'hff);
    rd(WRS_ADDR_POWER_CONTROL, 8'h20, 1'b1);
    lv = 1'b1;
    wt(10);
    `CHK("lvr off", 1'b1, rst_b)
    lv = 1'b0;
    i_cpu.sfr_wr(WRS_ADDR_POWER_CONTROL, 8'h00);
    lv = 1'b1;
    wt(6);
    `CHK("lvr on", 1'b0, rst_b)
    lv = 1'b0;
    wt(15);
    `CHK("lvr hold", 1'b0, rst_b)
    wt(15);
    `CHK("lvr end", 1'b1, rst_b)
    `CHK("lvr cause", 4'b0100, cause)
    rd(WRS_ADDR_WATCHDOG_KEY, WRS_KEY_RESET, 1'b1);
    rd(WRS_ADDR_POWER_CONTROL, 8'h00, 1'b1);
    se0 = 1'b1;
    wt(5);
    se0 = 1'b0;
    wt(10);
    `CHK("short se0", 1'b0, flag)
    se0 = 1'b1;
    wt(20);
    `CHK("flag", 1'b1, flag)
    `CHK("no usb reset", 1'b1, rst_b)
    se0 = 1'b0;
    wt(6);
    clr = 1'b1;
    wt(1);
    clr = 1'b0;
    wt(1);
    `CHK("flag clr", 1'b0, flag)
    en = 1'b1;
    se0 = 1'b1;
    wt(20);
    `CHK("usb reset", 1'b0, rst_b)
    se0 = 1'b0;
    wt(10);
    `CHK("usb release", 1'b1, rst_b)
    `CHK("usb cause", 4'b0001, cause)
    final_report;
  end
endmodule
